// ==== hw/sdram_cfg_pkg.sv ====
// Purpose: Constants and types of the SDRAM controller configuration block
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz core clock mclk
// Notes: Function list below
// Function
// - Three 2-bit strength codes for data, address/bank and command lines
// - Ratio code 001..111 gives divide 2..5 in half steps; 000 reserved
// - Refresh interval in core clocks; zero turns refresh off
// - Bank-to-bank refresh gap of 0, 1, 2 or 4 memory clocks
// - Address setup stretch adds one clock before chip select
// - Fair arbitration or processor first unless display is urgent
// - Management window at base plus 400000 maps to A0000..BFFFF
// - 2-bit strength code for all memory clock outputs
// - Five active-low gates, one per memory clock output
// - Clock shift in half core clocks, taken when start bit rises
// - Read data captured one or two core clocks after clock edge
// - At most two banks and eight devices
// - Module bank bit selects one or two module banks
// - Component bank bit, zero means two component banks
package sdram_cfg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          AXI_AW     = 16;
  localparam logic [15:0] OFS_CTL_A  = 16'h8400;
  localparam logic [15:0] OFS_CTL_B  = 16'h8404;
  localparam logic [15:0] OFS_BANK   = 16'h8408;
  localparam logic [15:0] OFS_TIM    = 16'h840c;
  localparam logic [15:0] OFS_GBASE  = 16'h8414;
  localparam logic [15:0] OFS_DRI    = 16'h8418;
  localparam logic [15:0] OFS_DRA    = 16'h841c;
  localparam logic [31:0] RST_CTL_A  = 32'h248c0040;
  localparam logic [31:0] RST_CTL_B  = 32'h00000801;
  localparam logic [31:0] RST_BANK   = 32'h41104110;
  localparam logic [31:0] RST_TIM    = 32'h2a733225;
  localparam logic [31:0] RST_ZERO   = 32'h00000000;
  localparam logic [1:0]  RESP_OK    = 2'b00;
  localparam logic [1:0]  RESP_SLV   = 2'b10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int A_DATA  = 30;
  localparam int A_ADDR  = 27;
  localparam int A_CMD   = 24;
  localparam int A_RATIO = 18;
  localparam int A_GO    = 17;
  localparam int A_RFIV  = 8;
  localparam int A_STAG  = 6;
  localparam int A_SETUP = 5;
  localparam int A_FAIR  = 3;
  localparam int A_REMAP = 2;
  localparam int A_PROG  = 0;
  localparam int B_CLKS  = 12;
  localparam int B_GATE  = 6;
  localparam int B_SHIFT = 3;
  localparam int B_RDPH  = 1;
  localparam int K_MOD   = 14;
  localparam int K_COMP  = 12;
  localparam int K_SIZE  = 8;
  localparam int T_CAS   = 28;
  localparam int DR_AW   = 10;
  // ----------------------------------------------------------------
  // Codes and windows
  // ----------------------------------------------------------------
  localparam logic [2:0]  RATIO_RSVD = 3'h0;
  localparam logic [2:0]  SHIFT_RSVD = 3'h7;
  localparam logic [2:0]  RATIO_DFLT = 3'h3;
  localparam logic [3:0]  HALF_BIAS  = 4'h3;
  localparam logic [3:0]  HALF_STEP  = 4'h2;
  localparam logic [31:0] MGMT_BASE  = 32'h00400000;
  localparam logic [31:0] MGMT_SIZE  = 32'h00020000;
  localparam logic [31:0] MGMT_PHYS  = 32'h000a0000;
  localparam int          MCLK_NS    = 50;

  typedef enum {RF_IDLE, RF_GAP} rf_state_e;

  typedef struct packed {
    logic [1:0] data;
    logic [1:0] addr;
    logic [1:0] cmd;
    logic [1:0] clk;
  } pad_cfg_s;

  typedef struct packed {
    logic       two_mod;
    logic       comp;
    logic [2:0] size;
  } geom_s;
endpackage

// ==== hw/sdram_cfg.sv ====
// Purpose: Configuration, clocking and refresh control of the SDRAM controller
// Assumes: Feedback clock arrives from the pin, other inputs on mclk
// Notes: Half-core-clock shift and ratio steps are approximated on mclk
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg
  import sdram_cfg_pkg::*;
#(
  parameter int BANKS = 2
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              memclk_fb,
  input  wire logic              cmd_start,
  input  wire logic              cpu_req,
  input  wire logic              disp_req,
  input  wire logic              disp_hi,
  input  wire logic [31:0]       sys_addr,
  output logic [4:0]             memory_clock_out,
  output logic [BANKS-1:0]       refresh_req,
  output logic                   mode_register_load,
  output logic [2:0]             cas_latency_code,
  output logic                   read_capture,
  output logic                   addr_drive,
  output logic                   cs_n,
  output logic                   grant_cpu,
  output logic                   grant_disp,
  output logic [31:0]            phys_addr,
  output pad_cfg_s               pad_cfg,
  output geom_s                  geom
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0]       ctl_a_r, ctl_b_r, bank_r, tim_r, gbase_r, dri_r;
  logic [1:0]        dr_mem [2**DR_AW];
  logic [AXI_AW-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_ok_r, w_ok_r;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_do   = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire ws_a    = waddr_r == OFS_CTL_A;
  wire ws_b    = waddr_r == OFS_CTL_B;
  wire ws_k    = waddr_r == OFS_BANK;
  wire ws_t    = waddr_r == OFS_TIM;
  wire ws_g    = waddr_r == OFS_GBASE;
  wire ws_i    = waddr_r == OFS_DRI;
  wire ws_d    = waddr_r == OFS_DRA;
  wire w_hit   = ws_a | ws_b | ws_k | ws_t | ws_g | ws_i | ws_d;
  wire [DR_AW-1:0] dr_idx = dri_r[DR_AW-1:0];
  wire [15:0] ra = s_axi_araddr;
  wire r_hit = ra == OFS_CTL_A || ra == OFS_CTL_B || ra == OFS_BANK || ra == OFS_TIM ||
               ra == OFS_GBASE || ra == OFS_DRI || ra == OFS_DRA;
  wire [31:0] rd_mux = ra == OFS_CTL_A ? ctl_a_r :
                       ra == OFS_CTL_B ? ctl_b_r :
                       ra == OFS_BANK  ? bank_r  :
                       ra == OFS_TIM   ? tim_r   :
                       ra == OFS_GBASE ? gbase_r :
                       ra == OFS_DRI   ? dri_r   :
                       ra == OFS_DRA   ? {30'h0, dr_mem[dr_idx]} : RST_ZERO;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_ok_r       <= 1'b0;
      w_ok_r        <= 1'b0;
      waddr_r       <= '0;
      wdata_r       <= RST_ZERO;
      wstrb_r       <= 4'h0;
    end else begin
      if (aw_take) begin
        waddr_r       <= s_axi_awaddr;
        aw_ok_r       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_ok_r       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? RESP_OK : RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_a_r <= RST_CTL_A;
      ctl_b_r <= RST_CTL_B;
      bank_r  <= RST_BANK;
      tim_r   <= RST_TIM;
      gbase_r <= RST_ZERO;
      dri_r   <= RST_ZERO;
    end else if (wr_do) begin
      if (ws_a) ctl_a_r <= wmerge(ctl_a_r, wdata_r, wstrb_r);
      if (ws_b) ctl_b_r <= wmerge(ctl_b_r, wdata_r, wstrb_r);
      if (ws_k) bank_r  <= wmerge(bank_r, wdata_r, wstrb_r);
      if (ws_t) tim_r   <= wmerge(tim_r, wdata_r, wstrb_r);
      if (ws_g) gbase_r <= wmerge(gbase_r, wdata_r, wstrb_r);
      if (ws_i) dri_r   <= wmerge(dri_r, wdata_r, wstrb_r);
    end
  end

  // Dirty RAM has no reset: it is a memory, cleared by software
  always_ff @(posedge mclk) begin
    if (wr_do && ws_d && wstrb_r[0]) dr_mem[dr_idx] <= wdata_r[1:0];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_ZERO;
      s_axi_rresp   <= RESP_OK;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= r_hit ? RESP_OK : RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Memory clock generation
  // ----------------------------------------------------------------
  logic       go_prev_r, prog_prev_r, run_r;
  logic [2:0] div_act_r, shift_act_r;
  logic [3:0] acc_r;
  logic [2:0] dl_r;
  wire [2:0] ratio_w = ctl_a_r[A_RATIO +: 3];
  wire [2:0] shift_w = ctl_b_r[B_SHIFT +: 3];
  wire go_rise   = ctl_a_r[A_GO] & ~go_prev_r;
  wire prog_rise = ctl_a_r[A_PROG] & ~prog_prev_r;
  // Period in half core clocks: code 1 gives 4, code 7 gives 10
  wire [3:0] per     = {1'b0, div_act_r} + HALF_BIAS;
  wire [3:0] acc_sum = acc_r + HALF_STEP;
  wire       wrap    = acc_sum >= per;
  wire [3:0] acc_nxt = wrap ? acc_sum - per : acc_sum;
  wire       tick    = run_r & wrap;
  // Odd periods toggle on whole core clocks, so duty is not exactly half
  wire       raw     = run_r & (acc_r < {1'b0, per[3:1]});
  wire [3:0] taps    = {dl_r, raw};
  wire       shifted = taps[shift_act_r[2:1]];

  always_ff @(posedge mclk) begin
    if (rst) begin
      go_prev_r   <= 1'b0;
      prog_prev_r <= 1'b0;
      run_r       <= 1'b0;
      div_act_r   <= RATIO_DFLT;
      shift_act_r <= 3'h0;
      acc_r       <= 4'h0;
      dl_r        <= 3'h0;
    end else begin
      go_prev_r   <= ctl_a_r[A_GO];
      prog_prev_r <= ctl_a_r[A_PROG];
      if (go_rise) begin
        run_r <= 1'b1;
        acc_r <= 4'h0;
        if (ratio_w != RATIO_RSVD) div_act_r <= ratio_w;
        if (shift_w != SHIFT_RSVD) shift_act_r <= shift_w;
      end else begin
        acc_r <= run_r ? acc_nxt : 4'h0;
      end
      dl_r <= {dl_r[1:0], raw};
    end
  end

  // One register for all five outputs keeps a single writer per variable
  wire [4:0] mco_nxt;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_gate
      assign mco_nxt[g] = shifted & ~ctl_b_r[B_GATE + g];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) memory_clock_out <= 5'h00;
    else memory_clock_out <= mco_nxt;
  end

  // ----------------------------------------------------------------
  // Read capture from the fed-back clock
  // ----------------------------------------------------------------
  logic fb_s1_r, fb_s2_r, fb_s3_r, fb_d_r;
  wire  fb_rise = fb_s2_r & ~fb_s3_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_s1_r      <= 1'b0;
      fb_s2_r      <= 1'b0;
      fb_s3_r      <= 1'b0;
      fb_d_r       <= 1'b0;
      read_capture <= 1'b0;
    end else begin
      fb_s1_r      <= memclk_fb;
      fb_s2_r      <= fb_s1_r;
      fb_s3_r      <= fb_s2_r;
      fb_d_r       <= fb_rise;
      read_capture <= ctl_b_r[B_RDPH] ? fb_d_r : fb_rise;
    end
  end

  // ----------------------------------------------------------------
  // Refresh
  // ----------------------------------------------------------------
  rf_state_e  rf_st_r;
  logic [8:0] rf_cnt_r;
  logic [2:0] gap_r;
  wire [8:0] ival   = ctl_a_r[A_RFIV +: 9];
  wire [1:0] stag   = ctl_a_r[A_STAG +: 2];
  wire       rf_hit = (ival != 9'h0) && (rf_cnt_r == ival - 9'h1);
  wire [2:0] gap_n  = stag == 2'b11 ? 3'h4 : {1'b0, stag};
  // Second bank is refreshed only when fitted, so a one-bank board ignores the gap
  wire       two_bk = (BANKS > 1) & bank_r[K_MOD];

  always_ff @(posedge mclk) begin
    if (rst) begin
      rf_st_r     <= RF_IDLE;
      rf_cnt_r    <= 9'h0;
      gap_r       <= 3'h0;
      refresh_req <= '0;
    end else begin
      refresh_req <= '0;
      rf_cnt_r    <= (ival == 9'h0 || rf_hit) ? 9'h0 : rf_cnt_r + 9'h1;
      case (rf_st_r)
        RF_IDLE: begin
          if (rf_hit) begin
            refresh_req[0] <= 1'b1;
            if (two_bk && gap_n == 3'h0) refresh_req[BANKS-1] <= 1'b1;
            else if (two_bk) begin
              rf_st_r <= RF_GAP;
              gap_r   <= gap_n;
            end
          end
        end
        RF_GAP: begin
          // Bank 0 keeps its own interval even while bank 1 still waits
          refresh_req[0] <= rf_hit;
          if (tick) begin
            gap_r <= gap_r - 3'h1;
            if (gap_r == 3'h1) begin
              refresh_req[BANKS-1] <= 1'b1;
              rf_st_r              <= RF_IDLE;
            end
          end
        end
        default: rf_st_r <= RF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command setup, arbitration, remap and static settings
  // ----------------------------------------------------------------
  logic wait_r, fair_last_r;
  wire  fair   = ctl_a_r[A_FAIR];
  wire  both   = cpu_req & disp_req;
  wire  pick_c = both ? (fair ? fair_last_r : ~disp_hi) : cpu_req;
  wire [31:0] win_off = sys_addr - MGMT_BASE;
  wire  in_win = ctl_a_r[A_REMAP] & (sys_addr >= MGMT_BASE) & (win_off < MGMT_SIZE);

  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_drive         <= 1'b0;
      cs_n               <= 1'b1;
      wait_r             <= 1'b0;
      grant_cpu          <= 1'b0;
      grant_disp         <= 1'b0;
      fair_last_r        <= 1'b0;
      phys_addr          <= RST_ZERO;
      mode_register_load <= 1'b0;
      cas_latency_code   <= 3'h0;
      pad_cfg            <= '0;
      geom               <= '0;
    end else begin
      if (cmd_start && !addr_drive) begin
        addr_drive <= 1'b1;
        wait_r     <= ctl_a_r[A_SETUP];
      end else if (addr_drive && tick) begin
        if (wait_r) wait_r <= 1'b0;
        else if (cs_n) cs_n <= 1'b0;
        else begin
          cs_n       <= 1'b1;
          addr_drive <= 1'b0;
        end
      end
      grant_cpu  <= pick_c;
      grant_disp <= disp_req & ~pick_c;
      if (both) fair_last_r <= ~pick_c;
      phys_addr <= in_win ? MGMT_PHYS + win_off : sys_addr;
      mode_register_load <= prog_rise;
      if (prog_rise) cas_latency_code <= tim_r[T_CAS +: 3];
      pad_cfg <= '{ctl_a_r[A_DATA +: 2], ctl_a_r[A_ADDR +: 2], ctl_a_r[A_CMD +: 2],
                   ctl_b_r[B_CLKS +: 2]};
      geom <= '{bank_r[K_MOD], bank_r[K_COMP], bank_r[K_SIZE +: 3]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_ratio_hold: assert property (!go_rise |=> $stable(div_act_r))
    else $error("ratio changed without start edge");
  chk_ratio_take: assert property (go_rise && ratio_w != RATIO_RSVD
    |=> div_act_r == $past(ratio_w) && run_r)
    else $error("ratio not taken on start edge");
  chk_refresh_off: assert property ((ival == 9'h0)[*3] |-> refresh_req[0] == 1'b0)
    else $error("refresh while interval is zero");
  chk_refresh_gap: assert property (refresh_req[0] && ival > 9'h1 && $stable(ival)
    |=> !refresh_req[0])
    else $error("refresh repeated too soon");
  chk_stagger_zero: assert property (rf_hit && rf_st_r == RF_IDLE && two_bk && stag == 2'b00
    |=> refresh_req == 2'b11)
    else $error("zero gap did not refresh both banks");
  chk_clock_gate: assert property (ctl_b_r[B_GATE] |=> !memory_clock_out[0])
    else $error("gated clock output toggled");
  chk_mode_load: assert property (prog_rise
    |=> mode_register_load && cas_latency_code == $past(tim_r[T_CAS +: 3]))
    else $error("mode load missing or wrong latency");
  chk_read_phase: assert property (fb_rise && !ctl_b_r[B_RDPH] |=> read_capture)
    else $error("read capture not one clock after edge");
  chk_arb_cpu: assert property (both && !fair && !disp_hi |=> grant_cpu && !grant_disp)
    else $error("processor lost fixed priority");
  chk_remap_win: assert property (in_win |=> phys_addr == MGMT_PHYS + $past(win_off))
    else $error("management window not remapped");

  cov_go: cover property (go_rise ##1 run_r);
  cov_stagger: cover property (rf_st_r == RF_GAP ##[1:40] refresh_req[1]);
  cov_setup: cover property (cmd_start && ctl_a_r[A_SETUP] ##[1:20] !cs_n);
endmodule // sdram_cfg
`default_nettype wire

// ==== bench/fb_pin_model.sv ====
// Purpose: Board-side loop of the memory feedback clock back into the block
// Assumes: A short trace delay that is fixed
// Notes: A gated-off output leaves the driven line low, so the return is low too
`timescale 1ns/1ps
`default_nettype none
module fb_pin_model (
  input  wire logic fb_out,
  output var  logic fb_in
);
  // Delay keeps the returned edge away from the core clock edge
  initial fb_in = 1'b0;
  always @(fb_out) fb_in <= #7 fb_out;
endmodule // fb_pin_model
`default_nettype wire

// ==== bench/sdram_cfg_tb.sv ====
// Purpose: Self-checking bench of the SDRAM configuration block
// Assumes: AXI4-Lite master in the bench, feedback clock looped by a pin model
// Notes: Expected values come from a register model and the field rules
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_tb
  import sdram_cfg_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, cmd_start = 1'b0, cpu_req = 1'b0;
  logic        disp_req = 1'b0, disp_hi = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
  logic        ar_v = 1'b0, r_r = 1'b0, prv;
  logic [15:0] aw_a = 16'h0000, ar_a = 16'h0000, ofs [7];
  logic [31:0] w_d = 32'h0, sys_addr = 32'h0, rnd = 32'h00000053, r_d, phys, d, mdl [7];
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, fb, cap, mrl, adrv, cs_n, g_cpu, g_disp;
  logic [1:0]  b_resp, r_resp, rf, resp;
  logic [2:0]  cas;
  logic [4:0]  mco;
  pad_cfg_s    pad;
  geom_s       geom;
  int          bad_count = 0, tests_run = 0, c, c0, i;

  always #25 mclk = ~mclk;

  sdram_cfg #(.BANKS(2)) DUT (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .memclk_fb(fb), .cmd_start(cmd_start),
    .cpu_req(cpu_req), .disp_req(disp_req), .disp_hi(disp_hi), .sys_addr(sys_addr),
    .memory_clock_out(mco), .refresh_req(rf), .mode_register_load(mrl),
    .cas_latency_code(cas), .read_capture(cap), .addr_drive(adrv), .cs_n(cs_n),
    .grant_cpu(g_cpu), .grant_disp(g_disp), .phys_addr(phys), .pad_cfg(pad), .geom(geom));

  fb_pin_model PIN (.fb_out(mco[4]), .fb_in(fb));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] ca(input logic [2:0] rt, input logic go,
                                     input logic [8:0] iv, input logic [7:0] lo);
    return {11'h000, rt, go, iv, lo};
  endfunction

  function automatic logic probe(input int k);
    case (k)
      0: return rf[0];
      1: return mco[0];
      3: return cap;
      4: return mrl;
      5: return ~cs_n;
      default: return fb;
    endcase
  endfunction

  task automatic print_verdict(input int extra);
    bad_count += extra;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait until a probed output reaches a level; n+1 edges elapsed
  task automatic wt(input int k, input logic v, output int n);
    for (n = 0; n < 300; n++) begin
      @(posedge mclk);
      if (probe(k) === v) break;
    end
    if (n == 300) print_verdict(1);
  endtask

  task automatic per(output int p);
    int a, b;
    wt(1, 1'b0, a);
    wt(1, 1'b1, a);
    wt(1, 1'b0, a);
    wt(1, 1'b1, b);
    p = a + b + 2;
  endtask

  task automatic axw(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge mclk);
    aw_a <= a;
    w_d  <= v;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
      if (b_v) break;
    end
    b_r <= 1'b0;
    r = b_resp;
    if (n == 40) print_verdict(1);
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge mclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (ar_rdy) ar_v <= 1'b0;
      if (r_v) break;
    end
    r_r <= 1'b0;
    v = r_d;
    r = r_resp;
    if (n == 40) print_verdict(1);
  endtask

  task automatic wr(input int k, input logic [31:0] v);
    axw(ofs[k], v, resp);
    chk(resp, RESP_OK);
    mdl[k] = v;
  endtask

  task automatic rb(input int k);
    axr(ofs[k], d, resp);
    chk(d, mdl[k]);
    chk(resp, RESP_OK);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ofs = '{OFS_CTL_A, OFS_CTL_B, OFS_BANK, OFS_TIM, OFS_GBASE, OFS_DRI, OFS_DRA};
    mdl = '{RST_CTL_A, RST_CTL_B, RST_BANK, RST_TIM, RST_ZERO, RST_ZERO, RST_ZERO};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rb(i);
    axr(16'h8410, d, resp);
    chk(resp, RESP_SLV);
    axw(16'h8420, 32'h1, resp);
    chk(resp, RESP_SLV);
    for (i = 2; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(i, rnd);
      rb(i);
    end
    chk(geom, {mdl[2][14], mdl[2][12], mdl[2][10:8]});
    wr(6, 32'h2);
    axr(OFS_DRA, d, resp);
    chk(d[1:0], 2'b10);
    rnd = lfsr(rnd);
    wr(0, rnd & 32'hdb000000);
    rnd = lfsr(rnd);
    wr(1, rnd & 32'h00003000);
    @(posedge mclk);
    chk(pad, {mdl[0][31:30], mdl[0][28:27], mdl[0][25:24], mdl[1][13:12]});
    $display("test registers complete");
    wr(0, ca(3'h3, 1'b0, 9'h000, 8'h00));
    wr(0, ca(3'h3, 1'b0, 9'h000, 8'h01));
    wt(4, 1'b1, c);
    chk(cas, mdl[3][30:28]);
    $display("test mode load complete");
    wr(1, 32'h0);
    for (i = 1; i < 8; i += 2) begin
      wr(0, ca(i[2:0], 1'b0, 9'h000, 8'h00));
      wr(0, ca(i[2:0], 1'b1, 9'h000, 8'h00));
      per(c);
      chk(c, (i + 3) / 2);
    end
    wr(0, ca(3'h1, 1'b1, 9'h000, 8'h00));
    per(c);
    chk(c, 5);
    wr(0, ca(3'h0, 1'b0, 9'h000, 8'h00));
    wr(0, ca(3'h0, 1'b1, 9'h000, 8'h00));
    per(c);
    chk(c, 5);
    wr(0, ca(3'h1, 1'b0, 9'h000, 8'h00));
    wr(0, ca(3'h1, 1'b1, 9'h000, 8'h00));
    per(c);
    chk(c, 2);
    wr(1, 32'h000001c0);
    @(posedge mclk);
    c = 0;
    for (i = 0; i < 12; i++) begin
      @(posedge mclk);
      chk(mco[2:0], 3'h0);
      c += mco[3];
    end
    chk(c, 6);
    wr(1, 32'h0);
    $display("test memory clock complete");
    for (i = 0; i < 3; i++) begin
      if (i == 2) begin
        wr(1, 32'h00000010);
        wr(0, ca(3'h1, 1'b0, 9'h000, 8'h00));
      end
      wr(0, ca(3'h1, 1'b1, 9'h000, i == 1 ? 8'h20 : 8'h00));
      wt(1, 1'b0, c);
      wt(1, 1'b1, c);
      cmd_start <= 1'b1;
      @(posedge mclk);
      cmd_start <= 1'b0;
      wt(5, 1'b1, c);
      chk(adrv, 1'b1);
      if (i == 0) c0 = c;
      if (i == 1) chk(c - c0, 2);
    end
    // Clock delayed one core clock against the command sequence
    chk(c - c0, 1);
    for (i = 0; i < 2; i++) begin
      wr(1, 32'h400 | (i << 1));
      repeat (8) @(posedge mclk);
      wr(1, i << 1);
      wt(6, 1'b1, c);
      wt(3, 1'b1, c);
      if (i == 0) c0 = c;
    end
    chk(c - c0, 1);
    $display("test setup and capture complete");
    wr(2, RST_BANK);
    wr(0, ca(3'h1, 1'b1, 9'h006, 8'h00));
    wt(0, 1'b1, c);
    chk(rf, 2'b11);
    wt(0, 1'b1, c);
    chk(c + 1, 6);
    wr(0, ca(3'h1, 1'b1, 9'h006, 8'h40));
    wt(0, 1'b1, c);
    chk(rf[1], 1'b0);
    wr(2, RST_BANK & 32'hffffbfff);
    wr(0, ca(3'h1, 1'b1, 9'h009, 8'h00));
    wt(0, 1'b1, c);
    wt(0, 1'b1, c);
    chk(c + 1, 9);
    chk(rf, 2'b01);
    wr(0, ca(3'h1, 1'b1, 9'h000, 8'h00));
    repeat (2) @(posedge mclk);
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      chk(rf, 2'b00);
    end
    $display("test refresh complete");
    wr(0, ca(3'h1, 1'b1, 9'h000, 8'h04));
    cpu_req <= 1'b1;
    disp_req <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      sys_addr <= MGMT_BASE + {15'h0, rnd[16:0]};
      disp_hi <= rnd[0];
      repeat (2) @(posedge mclk);
      chk(phys, MGMT_PHYS + {15'h0, rnd[16:0]});
      chk({g_cpu, g_disp}, {~rnd[0], rnd[0]});
    end
    wr(0, ca(3'h1, 1'b1, 9'h000, 8'h08));
    sys_addr <= MGMT_BASE + 32'h10;
    disp_hi <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(phys, MGMT_BASE + 32'h10);
    prv = g_cpu;
    @(posedge mclk);
    chk({g_cpu, g_disp}, {~prv, prv});
    $display("test remap and arbitration complete");
    print_verdict(0);
  end
endmodule // sdram_cfg_tb
`default_nettype wire
